/* prd_pkg.sv */
// Purpose: Shared constants and types for the packed-ring driver engine
// Assumes: 32-bit APB register access, 32-bit word memory port
// Notes: All offsets and codes live here, and the field positions except those of the packed read-back words

package prd_pkg;

  // ---------------------------------------------
  // Descriptor layout
  // ---------------------------------------------
  localparam int DESC_WORDS = 4;
  localparam logic [1:0] W_ADDR_LO = 2'h0;
  localparam logic [1:0] W_ADDR_HI = 2'h1;
  localparam logic [1:0] W_LEN = 2'h2;
  localparam logic [1:0] W_ID_FLAGS = 2'h3;
  localparam int FLAG_CHAIN = 0;
  localparam int FLAG_WRITABLE = 1;
  localparam int FLAG_INDIRECT = 2;
  localparam int FLAG_AVAIL = 7;
  localparam int FLAG_CONSUMED = 15;
  localparam logic WRAP_RESET = 1'b1;

  // ---------------------------------------------
  // Event suppression word
  // ---------------------------------------------
  localparam logic [1:0] EVT_ENABLE = 2'h0;
  localparam logic [1:0] EVT_DISABLE = 2'h1;
  localparam logic [1:0] EVT_DESC = 2'h2;
  localparam int EVT_WRAP_BIT = 15;
  localparam int EVT_CODE_LO = 16;

  // ---------------------------------------------
  // Register offsets
  // ---------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_QSIZE = 8'h04;
  localparam logic [7:0] REG_RING_LO = 8'h08;
  localparam logic [7:0] REG_RING_HI = 8'h0c;
  localparam logic [7:0] REG_DEVEVT_LO = 8'h10;
  localparam logic [7:0] REG_DEVEVT_HI = 8'h14;
  localparam logic [7:0] REG_DRVEVT_LO = 8'h18;
  localparam logic [7:0] REG_DRVEVT_HI = 8'h1c;
  localparam logic [7:0] REG_EL_ADDR_LO = 8'h20;
  localparam logic [7:0] REG_EL_ADDR_HI = 8'h24;
  localparam logic [7:0] REG_EL_LEN = 8'h28;
  localparam logic [7:0] REG_EL_CTRL = 8'h2c;
  localparam logic [7:0] REG_STATUS = 8'h30;
  localparam logic [7:0] REG_USED_INFO = 8'h34;
  localparam logic [7:0] REG_USED_LEN = 8'h38;
  localparam logic [7:0] REG_USED_POP = 8'h3c;
  localparam logic [7:0] REG_DRV_EVT = 8'h40;
  localparam logic [7:0] REG_KICK = 8'h44;

  // Field positions
  localparam int CTRL_POLL = 0;
  localparam int CTRL_ZERO = 1;
  localparam int CTRL_EVIDX = 2;
  localparam int ELC_WR = 16;
  localparam int ELC_IND = 17;
  localparam int ELC_LAST = 18;
  localparam int ST_BUSY = 0;
  localparam int ST_USED_VALID = 1;
  localparam int ST_RING_READY = 2;
  localparam int ST_AVAIL_WRAP = 3;
  localparam int ST_USED_WRAP = 4;
  localparam int ST_LIST_OPEN = 5;

  // ---------------------------------------------
  // Types
  // ---------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [63:0] addr;
    logic [31:0] wdata;
  } prd_mem_req_s;

  typedef struct packed {
    logic valid;
    logic wrap;
    logic [14:0] off;
  } prd_notify_s;

  typedef struct packed {
    logic [14:0] end_slot;
    logic end_wrap;
    logic [15:0] count;
  } prd_list_s;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ZERO = 8'h02,
    ST_DESC = 8'h04,
    ST_FLAGS = 8'h08,
    ST_EVRD = 8'h10,
    ST_POLL = 8'h20,
    ST_ULEN = 8'h40,
    ST_DRVWR = 8'h80
  } prd_state_e;

endpackage

/* prd_list_table.sv */
// Purpose: Per-buffer-id record of list end position and length
// Assumes: Ids below ID_DEPTH; write and read in one clock domain
// Notes: Asynchronous read so a pop completes in one cycle

`timescale 1ns/100ps

module prd_list_table #(
  parameter int ID_DEPTH = 256,
  parameter int IW = $clog2(ID_DEPTH)
) (
  // Clock and enable
  input wire logic pclk,
  input wire logic ce,
  // Write port
  input wire logic we,
  input wire logic [IW-1:0] widx,
  input wire prd_pkg::prd_list_s wdata,
  // Read port
  input wire logic [IW-1:0] ridx,
  output prd_pkg::prd_list_s rdata
);
  import prd_pkg::*;

  prd_list_s mem [ID_DEPTH];

  // No reset: entries are only read for ids already written
  always_ff @(posedge pclk) begin
    if (ce && we) begin
      mem[widx] <= wdata;
    end
  end

  assign rdata = mem[ridx];

endmodule

/* prd_ring_driver.sv */
// Purpose: Driver-side engine for a packed descriptor ring in shared memory
// Assumes: Software drives it over APB; memory port is word wide, held until ready
// Notes: Lists are built one element per register write; first flags written last

`timescale 1ns/100ps

module prd_ring_driver #(
  parameter int ID_DEPTH = 256,
  parameter logic [15:0] QSIZE_DEFAULT = 16'h0100
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shared ring memory
  output prd_pkg::prd_mem_req_s mem_req,
  input wire logic mem_ready,
  input wire logic [31:0] mem_rdata,
  // Device notification
  output prd_pkg::prd_notify_s notify
);
  import prd_pkg::*;

  localparam int IW = $clog2(ID_DEPTH);

  // ---------------------------------------------
  // Functions
  // ---------------------------------------------
  function automatic logic [63:0] desc_addr(input logic [63:0] base, input logic [14:0] slot,
                                            input logic [1:0] w);
    desc_addr = {base[63:4], 4'h0} + {45'h0, slot, 4'h0} + {60'h0, w, 2'h0};
  endfunction

  function automatic logic [14:0] slot_inc(input logic [14:0] slot, input logic [15:0] qs);
    slot_inc = ({1'b0, slot} == qs - 16'h1) ? 15'h0 : slot + 15'h1;
  endfunction

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  prd_state_e state;
  logic [1:0] widx;
  logic [17:0] zcnt;
  logic [15:0] qsize;
  logic [63:0] ring_base, devevt_base, drvevt_base;
  logic poll_en, evidx, ring_ready, zero_req;
  logic [63:0] el_addr;
  logic [31:0] el_len;
  logic [15:0] el_id;
  logic el_wr, el_ind, el_last, el_pend, el_first;
  logic [31:0] drv_evt_val;
  logic drv_evt_pend, kick_pend;
  logic [14:0] next_avail, next_used, list_first;
  logic avail_wrap, used_wrap, list_first_wrap;
  logic list_open, list_has_wr;
  logic [15:0] list_cnt, outstanding;
  logic [31:0] first_word3;
  logic used_valid, used_written;
  logic [15:0] used_id;
  logic [31:0] used_len;
  prd_list_s tab_rd, tab_wd;
  logic tab_we;

  // ---------------------------------------------
  // APB decode
  // ---------------------------------------------
  logic access, wr_acc, el_bad, evt_bad, mapped, refused;
  logic wr_el, wr_pop, wr_drv, wr_zero, wr_kick;
  logic [15:0] el_flags;
  logic [16:0] ring_need;

  assign access = psel && penable && ce;
  assign wr_acc = access && pwrite;
  assign pready = ce;
  assign ring_need = {1'b0, outstanding} + {1'b0, list_cnt};

  always_comb begin
    el_bad = el_pend || !ring_ready || zero_req;
    if (ring_need >= {1'b0, qsize}) begin
      el_bad = 1'b1;
    end
    if (list_has_wr && !pwdata[ELC_WR]) begin
      el_bad = 1'b1;
    end
    if (pwdata[ELC_IND] && (list_open || !pwdata[ELC_LAST] || el_len[3:0] != 4'h0 || el_len == 32'h0)) begin
      el_bad = 1'b1;
    end
  end

  // Reserved code 3 and descriptor mode without the feature are refused
  assign evt_bad = drv_evt_pend || pwdata[17:16] == 2'h3 || (pwdata[17:16] == EVT_DESC && !evidx);

  always_comb begin
    mapped = 1'b1;
    refused = 1'b0;
    case (paddr)
      REG_CTRL, REG_RING_LO, REG_RING_HI, REG_DEVEVT_LO, REG_DEVEVT_HI, REG_DRVEVT_LO, REG_DRVEVT_HI,
      REG_EL_ADDR_LO, REG_EL_ADDR_HI, REG_EL_LEN, REG_STATUS, REG_USED_INFO, REG_USED_LEN: begin
        refused = 1'b0;
      end
      REG_QSIZE: begin
        refused = pwdata[15:0] == 16'h0 || pwdata[15:0] > 16'h8000 || ring_ready;
      end
      REG_EL_CTRL: begin
        refused = el_bad;
      end
      REG_USED_POP: begin
        refused = !used_valid;
      end
      REG_DRV_EVT: begin
        refused = evt_bad;
      end
      REG_KICK: begin
        refused = kick_pend;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign pslverr = access && (!mapped || (pwrite && refused));
  assign wr_el = wr_acc && paddr == REG_EL_CTRL && !el_bad;
  assign wr_pop = wr_acc && paddr == REG_USED_POP && used_valid;
  assign wr_drv = wr_acc && paddr == REG_DRV_EVT && !evt_bad;
  assign wr_kick = wr_acc && paddr == REG_KICK && !kick_pend;
  assign wr_zero = wr_acc && paddr == REG_CTRL && pwdata[CTRL_ZERO] && !zero_req && qsize != 16'h0;

  // ---------------------------------------------
  // Configuration registers
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qsize <= QSIZE_DEFAULT;
      ring_base <= 64'h0;
      devevt_base <= 64'h0;
      drvevt_base <= 64'h0;
      poll_en <= 1'b0;
      evidx <= 1'b0;
      el_addr <= 64'h0;
      el_len <= 32'h0;
    end else if (wr_acc && !refused) begin
      case (paddr)
        REG_CTRL: begin
          poll_en <= pwdata[CTRL_POLL];
          evidx <= pwdata[CTRL_EVIDX];
        end
        REG_QSIZE: qsize <= pwdata[15:0];
        REG_RING_LO: ring_base[31:0] <= {pwdata[31:4], 4'h0};
        REG_RING_HI: ring_base[63:32] <= pwdata;
        REG_DEVEVT_LO: devevt_base[31:0] <= {pwdata[31:2], 2'h0};
        REG_DEVEVT_HI: devevt_base[63:32] <= pwdata;
        REG_DRVEVT_LO: drvevt_base[31:0] <= {pwdata[31:2], 2'h0};
        REG_DRVEVT_HI: drvevt_base[63:32] <= pwdata;
        REG_EL_ADDR_LO: el_addr[31:0] <= pwdata;
        REG_EL_ADDR_HI: el_addr[63:32] <= pwdata;
        REG_EL_LEN: el_len <= pwdata;
        default: begin
        end
      endcase
    end
  end

  // Read data is captured in the setup cycle, so it stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (ce && psel && !penable) begin
      case (paddr)
        REG_CTRL: prdata <= {29'h0, evidx, zero_req, poll_en};
        REG_QSIZE: prdata <= {16'h0, qsize};
        REG_RING_LO: prdata <= ring_base[31:0];
        REG_RING_HI: prdata <= ring_base[63:32];
        REG_DEVEVT_LO: prdata <= devevt_base[31:0];
        REG_DEVEVT_HI: prdata <= devevt_base[63:32];
        REG_DRVEVT_LO: prdata <= drvevt_base[31:0];
        REG_DRVEVT_HI: prdata <= drvevt_base[63:32];
        REG_EL_ADDR_LO: prdata <= el_addr[31:0];
        REG_EL_ADDR_HI: prdata <= el_addr[63:32];
        REG_EL_LEN: prdata <= el_len;
        REG_STATUS: prdata <= {outstanding, 10'h0, list_open, used_wrap, avail_wrap, ring_ready,
                               used_valid, (state != ST_IDLE) || el_pend};
        REG_USED_INFO: prdata <= {15'h0, used_written, used_id};
        REG_USED_LEN: prdata <= used_len;
        REG_KICK: prdata <= {16'h0, avail_wrap, next_avail};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // ---------------------------------------------
  // Element flags and list table
  // ---------------------------------------------
  always_comb begin
    el_flags = 16'h0;
    el_flags[FLAG_CHAIN] = !el_last && !el_ind;
    el_flags[FLAG_WRITABLE] = el_wr && !el_ind;
    el_flags[FLAG_INDIRECT] = el_ind;
    el_flags[FLAG_AVAIL] = avail_wrap;
    el_flags[FLAG_CONSUMED] = !avail_wrap;
  end

  assign tab_we = state == ST_FLAGS && mem_req.valid && mem_ready && ce;
  assign tab_wd = '{end_slot: next_avail, end_wrap: avail_wrap, count: list_cnt};

  prd_list_table #(.ID_DEPTH(ID_DEPTH), .IW(IW)) u_tab (
    .pclk(pclk),
    .ce(ce),
    .we(tab_we),
    .widx(el_id[IW-1:0]),
    .wdata(tab_wd),
    .ridx(used_id[IW-1:0]),
    .rdata(tab_rd)
  );

  // ---------------------------------------------
  // Ring engine
  // ---------------------------------------------
  logic ack, hit;
  logic [16:0] evt_pos, evt_dist;

  assign ack = mem_req.valid && mem_ready;
  // Target position, unrolled across one lap when its wrap differs
  assign evt_pos = (mem_rdata[EVT_WRAP_BIT] == list_first_wrap) ? {2'h0, mem_rdata[14:0]}
                   : {2'h0, mem_rdata[14:0]} + {1'b0, qsize};
  assign evt_dist = evt_pos - {2'h0, list_first};
  assign hit = evt_pos >= {2'h0, list_first} && evt_dist < {1'b0, list_cnt};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      widx <= 2'h0;
      zcnt <= 18'h0;
      mem_req <= '0;
      notify <= '0;
      ring_ready <= 1'b0;
      zero_req <= 1'b0;
      el_pend <= 1'b0;
      el_first <= 1'b0;
      el_id <= 16'h0;
      el_wr <= 1'b0;
      el_ind <= 1'b0;
      el_last <= 1'b0;
      drv_evt_pend <= 1'b0;
      drv_evt_val <= 32'h0;
      kick_pend <= 1'b0;
      next_avail <= 15'h0;
      next_used <= 15'h0;
      avail_wrap <= WRAP_RESET;
      used_wrap <= WRAP_RESET;
      list_open <= 1'b0;
      list_first <= 15'h0;
      list_first_wrap <= WRAP_RESET;
      list_cnt <= 16'h0;
      list_has_wr <= 1'b0;
      first_word3 <= 32'h0;
      outstanding <= 16'h0;
      used_valid <= 1'b0;
      used_written <= 1'b0;
      used_id <= 16'h0;
      used_len <= 32'h0;
    end else if (ce) begin
      notify.valid <= 1'b0;
      if (wr_zero) begin
        zero_req <= 1'b1;
      end
      if (wr_el) begin
        el_pend <= 1'b1;
        el_id <= pwdata[15:0];
        el_wr <= pwdata[ELC_WR];
        el_ind <= pwdata[ELC_IND];
        el_last <= pwdata[ELC_LAST];
      end
      if (wr_drv) begin
        drv_evt_pend <= 1'b1;
        drv_evt_val <= {14'h0, pwdata[17:0]};
      end
      if (wr_kick) begin
        kick_pend <= 1'b1;
      end
      if (wr_pop) begin
        // Whole list of the popped id retires at once
        used_valid <= 1'b0;
        next_used <= tab_rd.end_slot;
        used_wrap <= tab_rd.end_wrap;
      end
      outstanding <= outstanding + (tab_we ? list_cnt : 16'h0) - (wr_pop ? tab_rd.count : 16'h0);
      case (state)
        ST_IDLE: begin
          if (zero_req) begin
            state <= ST_ZERO;
            zcnt <= 18'h0;
            ring_ready <= 1'b0;
            mem_req <= '{valid: 1'b1, write: 1'b1, addr: {ring_base[63:4], 4'h0}, wdata: 32'h0};
          end else if (el_pend) begin
            state <= ST_DESC;
            widx <= W_ADDR_LO;
            el_first <= !list_open;
            if (!list_open) begin
              first_word3 <= {el_flags, el_id};
            end
            mem_req <= '{valid: 1'b1, write: 1'b1, addr: desc_addr(ring_base, next_avail, W_ADDR_LO),
                         wdata: el_addr[31:0]};
          end else if (drv_evt_pend) begin
            state <= ST_DRVWR;
            mem_req <= '{valid: 1'b1, write: 1'b1, addr: drvevt_base, wdata: drv_evt_val};
          end else if (kick_pend && !notify.valid) begin
            kick_pend <= 1'b0;
            notify <= '{valid: 1'b1, wrap: avail_wrap, off: next_avail};
          end else if (poll_en && ring_ready && !used_valid && outstanding != 16'h0) begin
            state <= ST_POLL;
            mem_req <= '{valid: 1'b1, write: 1'b0, addr: desc_addr(ring_base, next_used, W_ID_FLAGS),
                         wdata: 32'h0};
          end
        end
        ST_ZERO: begin
          if (ack) begin
            if (zcnt == {qsize, 2'h0} - 18'h1) begin
              mem_req.valid <= 1'b0;
              state <= ST_IDLE;
              zero_req <= 1'b0;
              ring_ready <= 1'b1;
              next_avail <= 15'h0;
              next_used <= 15'h0;
              avail_wrap <= WRAP_RESET;
              used_wrap <= WRAP_RESET;
              outstanding <= 16'h0;
              list_open <= 1'b0;
              list_cnt <= 16'h0;
              list_has_wr <= 1'b0;
            end else begin
              zcnt <= zcnt + 18'h1;
              mem_req.addr <= {ring_base[63:4], 4'h0} + {44'h0, zcnt + 18'h1, 2'h0};
            end
          end
        end
        ST_DESC: begin
          if (ack) begin
            // First element's id and flags word is held back until the list is complete
            if (widx == W_ID_FLAGS || (widx == W_LEN && el_first)) begin
              next_avail <= slot_inc(next_avail, qsize);
              if (slot_inc(next_avail, qsize) == 15'h0) begin
                avail_wrap <= !avail_wrap;
              end
              list_cnt <= list_cnt + 16'h1;
              list_open <= 1'b1;
              list_has_wr <= list_has_wr || el_wr;
              if (el_first) begin
                list_first <= next_avail;
                list_first_wrap <= avail_wrap;
              end
              if (el_last) begin
                state <= ST_FLAGS;
                mem_req <= '{valid: 1'b1, write: 1'b1,
                             addr: desc_addr(ring_base, el_first ? next_avail : list_first, W_ID_FLAGS),
                             wdata: el_first ? first_word3 : {first_word3[31:16], 16'h0}};
              end else begin
                mem_req.valid <= 1'b0;
                el_pend <= 1'b0;
                state <= ST_IDLE;
              end
            end else begin
              widx <= widx + 2'h1;
              mem_req.addr <= desc_addr(ring_base, next_avail, widx + 2'h1);
              case (widx)
                W_ADDR_LO: mem_req.wdata <= el_addr[63:32];
                W_ADDR_HI: mem_req.wdata <= el_len;
                default: mem_req.wdata <= {el_flags, el_id};
              endcase
            end
          end
        end
        ST_FLAGS: begin
          if (ack) begin
            list_open <= 1'b0;
            list_cnt <= 16'h0;
            list_has_wr <= 1'b0;
            el_pend <= 1'b0;
            state <= ST_EVRD;
            mem_req <= '{valid: 1'b1, write: 1'b0, addr: devevt_base, wdata: 32'h0};
          end
        end
        ST_EVRD: begin
          if (ack) begin
            mem_req.valid <= 1'b0;
            state <= ST_IDLE;
            if (mem_rdata[17:16] != EVT_DISABLE && (mem_rdata[17:16] != EVT_DESC || !evidx || hit)) begin
              notify <= '{valid: 1'b1, wrap: avail_wrap, off: next_avail};
            end
          end
        end
        ST_POLL: begin
          if (ack) begin
            // Used when both flag bits equal the expected wrap
            if (mem_rdata[16 + FLAG_CONSUMED] == used_wrap && mem_rdata[16 + FLAG_AVAIL] == used_wrap) begin
              used_id <= mem_rdata[15:0];
              used_written <= mem_rdata[16 + FLAG_WRITABLE];
              state <= ST_ULEN;
              mem_req.addr <= desc_addr(ring_base, next_used, W_LEN);
            end else begin
              mem_req.valid <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        ST_ULEN: begin
          if (ack) begin
            mem_req.valid <= 1'b0;
            used_len <= mem_rdata;
            used_valid <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_DRVWR: begin
          if (ack) begin
            mem_req.valid <= 1'b0;
            drv_evt_pend <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          mem_req.valid <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

/* prd_ring_monitor.sv */
// Purpose: Port checker for prd_ring_driver
// Assumes: Single clock, async active-low reset
// Notes: Bound from the bench top file
`timescale 1ns/100ps
module prd_ring_monitor import prd_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Memory and notify
  input wire prd_mem_req_s mem_req,
  input wire logic mem_ready,
  input wire prd_notify_s notify
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Zero fill writes zero flags, so only non-zero words count
  sequence s_flag_wr;
    mem_req.valid && mem_req.write && mem_req.addr[3:2] == 2'h3 && mem_req.wdata != 32'h0;
  endsequence
  AST_FLAG_AVAIL: assert property (s_flag_wr |-> mem_req.wdata[23] != mem_req.wdata[31])
    else $error("available and consumed flags not opposite");
  AST_INDIRECT_FLAGS: assert property (s_flag_wr ##0 mem_req.wdata[18] |-> mem_req.wdata[17:16] == 2'h0)
    else $error("indirect descriptor carries writable or chain");
  AST_REQ_HOLD: assert property (mem_req.valid && !mem_ready |=> $stable(mem_req))
    else $error("memory request changed before ready");
  AST_WORD_ALIGN: assert property (mem_req.valid |-> mem_req.addr[1:0] == 2'h0)
    else $error("memory word not aligned");
  AST_NOTIFY_PULSE: assert property (notify.valid |=> !notify.valid)
    else $error("notify longer than one cycle");
  AST_ERR_IDLE: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access phase");
  AST_UNMAPPED: assert property (psel && penable && paddr > 8'h44 |-> pslverr)
    else $error("unmapped access not refused");
  AST_READY_CE: assert property (pready == ce)
    else $error("pready differs from ce");
endmodule

/* prd_device_model.sv */
// Purpose: Shared memory and device side for the ring bench
// Assumes: Ring and suppression words within 512 bytes
// Notes: Slow mode stalls every other cycle
`timescale 1ns/100ps
module prd_device_model import prd_pkg::*; (
  // Clock and mode
  input wire logic pclk,
  input wire logic slow,
  // Memory port
  input wire prd_mem_req_s mem_req,
  output logic mem_ready,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [128];
  int stamp [128];
  int seq = 0;
  logic tick = 1'b0;
  wire [6:0] idx = mem_req.addr[8:2];
  // Non-zero fill so a missed zero pass shows up
  initial for (int i = 0; i < 128; i++) mem[i] = 32'ha5a5_a5a5;
  always @(posedge pclk) tick <= ~tick;
  assign mem_ready = slow ? tick : 1'b1;
  // Outside an answer the data lines show garbage
  assign mem_rdata = (mem_req.valid && mem_ready && !mem_req.write) ? mem[idx] : ~mem[idx];
  // Device never writes buffers or used slots here
  always @(posedge pclk) if (mem_req.valid && mem_ready && mem_req.write) begin
    mem[idx] <= mem_req.wdata;
    stamp[idx] <= seq;
    seq <= seq + 1;
  end
endmodule

/* prd_ring_driver_bench.sv */
// Purpose: Self-checking bench for prd_ring_driver
// Assumes: Ring at 0x100, queue of 4, suppression at 0x140/0x144
// Notes: ce stays high
`timescale 1ns/100ps
module prd_ring_driver_bench;
  import prd_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, slow = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, mem_ready, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, mem_rdata, rd;
  prd_mem_req_s mem_req;
  prd_notify_s notify, nlast;
  int error_cnt = 0, samples_checked = 0, ncnt = 0;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (notify.valid === 1'b1) begin
    ncnt <= ncnt + 1;
    nlast <= notify;
  end
  prd_ring_driver i_prd_ring_driver (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .notify(notify));
  prd_device_model i_dev (.pclk(pclk), .slow(slow), .mem_req(mem_req), .mem_ready(mem_ready), .mem_rdata(mem_rdata));
  task give_verdict;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Request held until pready is seen high at a rising edge; answer taken there
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    {err, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  task wait_st(input int b, input logic v);
    for (int i = 0; i < 400; i++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rd[b] === v) return;
    end
    error_cnt++;
    give_verdict();
  endtask
  task el(input logic [31:0] a, input logic [31:0] len, input logic [31:0] ctl);
    wait_st(ST_BUSY, 1'b0);
    apb(1'b1, REG_EL_ADDR_LO, a);
    apb(1'b1, REG_EL_ADDR_HI, 32'h0);
    apb(1'b1, REG_EL_LEN, len);
    apb(1'b1, REG_EL_CTRL, ctl);
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task t_early;
    apb(1'b0, 8'h80, 32'h0);
    chk("unmapped err", 1, err);
    el(32'h1000, 32'h40, 32'h0004_0005);
    chk("unready el err", 1, err);
  endtask
  task t_setup;
    i_dev.mem['h50] = 32'h0;
    apb(1'b1, REG_QSIZE, 32'h4);
    apb(1'b1, REG_RING_LO, 32'h100);
    apb(1'b1, REG_RING_HI, 32'h0);
    apb(1'b1, REG_DEVEVT_LO, 32'h140);
    apb(1'b1, REG_DEVEVT_HI, 32'h0);
    apb(1'b1, REG_DRVEVT_LO, 32'h144);
    apb(1'b1, REG_DRVEVT_HI, 32'h0);
    apb(1'b1, REG_CTRL, 32'h2);
    wait_st(ST_RING_READY, 1'b1);
    chk("wrap reset", 2'b11, rd[4:3]);
    for (int s = 0; s < 16; s++) chk("zero fill", 0, i_dev.mem['h40 + s]);
  endtask
  task t_single;
    slow <= 1'b1;
    el(32'h1000, 32'h40, 32'h0004_0005);
    chk("single err", 0, err);
    wait_st(ST_BUSY, 1'b0);
    chk("addr word", 32'h1000, i_dev.mem['h40]);
    chk("len word", 32'h40, i_dev.mem['h42]);
    chk("flag word", 32'h0080_0005, i_dev.mem['h43]);
    chk("notify count", 1, ncnt);
    chk("notify pos", {1'b1, 1'b1, 15'd1}, nlast);
  endtask
  task t_chain;
    el(32'h2000, 32'h10, 32'h0001_0000);
    chk("chain err", 0, err);
    el(32'h3000, 32'h10, 32'h0004_0000);
    chk("readable after writable", 1, err);
    el(32'h3000, 32'h10, 32'h0005_0007);
    wait_st(ST_BUSY, 1'b0);
    chk("chain flags", 16'h0083, i_dev.mem['h47][31:16]);
    chk("tail flags", 32'h0082_0007, i_dev.mem['h4b]);
    chk("first last", 1, i_dev.stamp['h47] > i_dev.stamp['h4b]);
  endtask
  task t_indirect;
    i_dev.mem['h50] = 32'h0001_0000;
    el(32'h4000, 32'h18, 32'h0007_0009);
    chk("partial table err", 1, err);
    el(32'h4000, 32'h20, 32'h0007_0009);
    wait_st(ST_BUSY, 1'b0);
    chk("indirect flags", 32'h0084_0009, i_dev.mem['h4f]);
    chk("suppressed notify", 2, ncnt);
    chk("avail wrap", 0, rd[ST_AVAIL_WRAP]);
    el(32'h5000, 32'h10, 32'h0004_000a);
    chk("ring full err", 1, err);
  endtask
  task t_evt;
    apb(1'b1, REG_DRV_EVT, 32'h0003_0000);
    chk("code 3 err", 1, err);
    apb(1'b1, REG_DRV_EVT, 32'h0002_0000);
    chk("code 2 err", 1, err);
    apb(1'b1, REG_DRV_EVT, 32'h0001_0000);
    chk("code 1 err", 0, err);
    for (int i = 0; i < 20 && i_dev.mem['h51] !== 32'h0001_0000; i++) apb(1'b0, REG_STATUS, 32'h0);
    chk("drv suppression", 32'h0001_0000, i_dev.mem['h51]);
  endtask
  // Bench plays the device: marks slots used in ring order
  task t_used;
    apb(1'b1, REG_KICK, 32'h0);
    i_dev.mem['h42] = 32'h20;
    i_dev.mem['h43] = 32'h8080_0005;
    apb(1'b1, REG_CTRL, 32'h1);
    wait_st(ST_USED_VALID, 1'b1);
    apb(1'b0, REG_USED_LEN, 32'h0);
    chk("used len", 32'h20, rd);
    apb(1'b1, REG_USED_POP, 32'h0);
    apb(1'b1, REG_USED_POP, 32'h0);
    chk("empty pop err", 1, err);
    i_dev.mem['h47] = 32'h8082_0007;
    wait_st(ST_USED_VALID, 1'b1);
    apb(1'b0, REG_USED_INFO, 32'h0);
    chk("used info", 32'h0001_0007, rd);
    apb(1'b1, REG_USED_POP, 32'h0);
    wait_st(ST_USED_VALID, 1'b0);
    chk("outstanding", 1, rd[31:16]);
    chk("kick notify", 3, ncnt);
    chk("kick pos", 32'h0001_0000, nlast);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_early();
    t_setup();
    t_single();
    t_chain();
    t_indirect();
    t_evt();
    t_used();
    give_verdict();
  end
endmodule
bind prd_ring_driver prd_ring_monitor i_prd_ring_monitor (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_ready(mem_ready),
  .notify(notify));
